// ### hw/hmb_top.v
// Purpose: source tracking, buck enable and thermal scheduling control
// Assumes: voltages arrive as 12-bit millivolt codes synchronous to clock
// Notes: device state is an input; analog stages live outside
//
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`include "hmb_regs.vh"
module hmb_top #(
  parameter PERIOD_BASE_US = 32'd1000000,
  parameter SAMPLE_BASE_US = 32'd1000,
  parameter THERM_US       = 32'd1000000,
  parameter THERM_EVAL_US  = 32'd100
) (
  input  wire        clock,
  input  wire        rst_b,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output reg  [1:0]  avs_response,
  input  wire [2:0]  device_state,
  input  wire [1:0]  source_regulation_select_pin,
  input  wire [4:0]  src1_cfg_pins,
  input  wire [4:0]  src2_cfg_pins,
  input  wire [2:0]  load_cfg_pins,
  input  wire [11:0] src1_mv,
  input  wire [11:0] src2_mv,
  input  wire [11:0] sto_mv,
  input  wire [11:0] load_mv,
  input  wire [11:0] load_target_mv,
  input  wire [11:0] charge_ready_threshold,
  input  wire [11:0] overdischarge_threshold,
  input  wire [11:0] low_source_threshold,
  input  wire [1:0]  source_energy_high,
  output reg  [1:0]  source_connect,
  output reg  [1:0]  tracking_active,
  output reg         resistance_ref_ground,
  output reg  [11:0] target1_mv,
  output reg  [11:0] target2_mv,
  output reg  [1:0]  high_power_mode,
  output reg         sleep_request,
  output reg         buck_enable,
  output reg  [2:0]  buck_voltage_code,
  output reg  [2:0]  buck_timing_code,
  output reg         direct_connect,
  output reg         thermal_divider_bias_pin,
  output reg         thermal_sample_strobe
);
  reg [7:0] ctrl;
  reg [7:0] reg0 [0:1];
  reg [7:0] reg1 [0:1];
  reg [7:0] buck_config_register;
  reg [31:0] tick_cnt;
  wire tick = (tick_cnt == `HMB_TICK_CYC - 1);
  wire use_regs = ctrl[`HMB_CTRL_USE_REGS];
  // tracking and constant voltage only regulate in these three states
  wire st_start     = (device_state == `HMB_ST_START);
  wire st_ovdis     = (device_state == `HMB_ST_OVDIS);
  wire st_supply    = (device_state == `HMB_ST_SUPPLY);
  wire active_state = st_start || st_ovdis || st_supply;
  wire [4:0] cfg_pins [0:1];
  assign cfg_pins[0] = src1_cfg_pins;
  assign cfg_pins[1] = src2_cfg_pins;
  wire [11:0] src_mv [0:1];
  assign src_mv[0] = src1_mv;
  assign src_mv[1] = src2_mv;
  wire [1:0] lvl_low;
  wire [2:0] load_code = use_regs ? buck_config_register[2:0] : load_cfg_pins;

  // one microsecond enable; every slower time base counts these pulses
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt <= 32'h0;
    end else if (tick) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end

  // per-input tracking sequencer
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_src
      wire        track_mode = use_regs ? reg0[gi][`HMB_REG0_MODE] : source_regulation_select_pin[gi];
      wire [2:0]  ratio = use_regs ? reg0[gi][2:0] : cfg_pins[gi][2:0];
      wire [1:0]  timing = use_regs ? reg1[gi][1:0] : cfg_pins[gi][4:3];
      wire        resistance_tracking_mode = (gi == 0) && (ratio == `HMB_RESISTANCE_TRACKING_MODE_CODE);
      wire [11:0] cv_level = {reg0[gi][6:3], 8'h00};
      // period scales by 4 per step, sampling duration by 2
      wire [31:0] period_us = PERIOD_BASE_US << {timing[1], 1'b0};
      wire [31:0] sample_us = SAMPLE_BASE_US << timing[0];
      reg  [31:0] us_cnt;
      reg         sampling;
      reg  [11:0] tgt;
      reg  [31:0] next_us_cnt;
      reg         next_sampling;
      reg  [11:0] next_tgt;
      wire [15:0] scaled = src_mv[gi] * ({1'b0, ratio} + 4'h9); // ratio (9+code)/16
      wire        run = active_state && track_mode;
      wire        period_done = (us_cnt >= period_us - 32'h1);
      wire        sample_done = (us_cnt >= sample_us - 32'h1);
      // constant voltage needs source above level before drawing
      wire        cv_draw = (src_mv[gi] > cv_level);
      wire        next_connect = active_state && (track_mode ? !sampling : cv_draw);
      assign lvl_low[gi] = use_regs && !track_mode && (cv_level < low_source_threshold);
      always @* begin
        next_us_cnt = us_cnt;
        next_sampling = sampling;
        next_tgt = tgt;
        // outside tracking the target follows the constant-voltage level
        if (!run) begin
          next_us_cnt = 32'h0;
          next_sampling = 1'b0;
          next_tgt = cv_level;
        end else if (tick) begin
          if (!sampling && period_done) begin
            next_us_cnt = 32'h0;
            next_sampling = 1'b1;
          end else if (sampling && sample_done) begin
            next_us_cnt = 32'h0;
            next_sampling = 1'b0;
            // hold target between samples
            if (resistance_tracking_mode) begin
              next_tgt = src_mv[gi];
            end else begin
              next_tgt = scaled[15:4];
            end
          end else begin
            next_us_cnt = us_cnt + 32'h1;
          end
        end
      end
      always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          us_cnt <= 32'h0;
          sampling <= 1'b0;
          tgt <= 12'h000;
        end else begin
          us_cnt <= next_us_cnt;
          sampling <= next_sampling;
          tgt <= next_tgt;
        end
      end
      always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          source_connect[gi] <= 1'b0;
          tracking_active[gi] <= 1'b0;
          high_power_mode[gi] <= 1'b0;
        end else begin
          tracking_active[gi] <= run;
          source_connect[gi] <= next_connect;
          high_power_mode[gi] <= source_energy_high[gi] && ctrl[`HMB_CTRL_HP1 + gi];
        end
      end
      if (gi == 0) begin : g_t1
        always @(posedge clock or negedge rst_b) begin
          if (!rst_b) begin
            target1_mv <= 12'h000;
            resistance_ref_ground <= 1'b0;
          end else begin
            target1_mv <= tgt;
            resistance_ref_ground <= resistance_tracking_mode && sampling && track_mode && active_state;
          end
        end
      end else begin : g_t2
        always @(posedge clock or negedge rst_b) begin
          if (!rst_b) begin
            target2_mv <= 12'h000;
          end else begin
            target2_mv <= tgt;
          end
        end
      end
    end
  endgenerate

  // buck and hysteretic bypass
  reg         buck_run;
  reg         next_buck_run;
  reg         next_direct;
  wire [12:0] headroom = {1'b0, sto_mv} - {1'b0, load_mv};
  // a negative difference wraps, so the order is tested first
  wire        small_room = (sto_mv < load_mv) || (headroom[11:0] < `HMB_HEADROOM_MV);
  wire        buck_off = (load_code == `HMB_BUCK_OFF);

  // run flag ignores device state; the state machine outside gates the converter
  always @* begin
    next_buck_run = buck_run;
    if (buck_off) begin
      next_buck_run = 1'b0;
    end else if (sto_mv > charge_ready_threshold) begin
      next_buck_run = 1'b1;
    end else if (sto_mv < overdischarge_threshold) begin
      next_buck_run = 1'b0;
    end
  end

  // no dead band around the target: the load capacitor sets the ripple
  always @* begin
    next_direct = direct_connect;
    if (!buck_run || !small_room) begin
      next_direct = 1'b0;
    end else if (load_mv < load_target_mv) begin
      next_direct = 1'b1;
    end else if (load_mv > load_target_mv) begin
      next_direct = 1'b0;
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      buck_run <= 1'b0;
      buck_enable <= 1'b0;
      direct_connect <= 1'b0;
      buck_voltage_code <= 3'h0;
      buck_timing_code <= 3'h0;
      sleep_request <= 1'b0;
    end else begin
      buck_run <= next_buck_run;
      buck_enable <= buck_run;
      buck_voltage_code <= load_code;
      buck_timing_code <= buck_config_register[5:3];
      direct_connect <= next_direct;
      sleep_request <= |lvl_low;
    end
  end

  // thermal scheduler
  reg  [31:0] th_cnt;
  wire        th_wrap = (th_cnt >= THERM_US - 32'h1);
  wire        th_in_eval = (th_cnt < THERM_EVAL_US - 32'h1);
  wire        th_eval_end = (th_cnt == THERM_EVAL_US - 32'h2);

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      th_cnt <= 32'h0;
    end else if (tick) begin
      if (th_wrap) begin
        th_cnt <= 32'h0;
      end else begin
        th_cnt <= th_cnt + 32'h1;
      end
    end
  end

  // bias rises one tick before the window so the divider has settled at the strobe
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      thermal_divider_bias_pin <= 1'b0;
      thermal_sample_strobe <= 1'b0;
    end else begin
      thermal_sample_strobe <= 1'b0;
      if (tick) begin
        thermal_divider_bias_pin <= th_in_eval || th_wrap;
        thermal_sample_strobe <= th_eval_end;
      end
    end
  end

  // avalon slave: request seen, then waitrequest low for exactly one cycle
  localparam BUS_IDLE   = 1'b0;
  localparam BUS_ANSWER = 1'b1;
  reg         bus_state;
  reg         next_bus_state;
  reg  [31:0] next_readdata;
  wire        req = avs_read || avs_write;
  wire        pend = (bus_state == BUS_ANSWER);
  wire        take = req && !pend;
  // writes land at the edge where the master samples waitrequest low
  wire        land = pend && avs_write && avs_byteenable[0];
  wire [7:0]  status_word = {sleep_request, direct_connect, buck_enable, high_power_mode,
                             tracking_active, resistance_ref_ground};

  always @* begin
    next_bus_state = BUS_IDLE;
    case (bus_state)
      BUS_IDLE: begin
        if (req) begin
          next_bus_state = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        next_bus_state = BUS_IDLE;
      end
      default: begin
        next_bus_state = BUS_IDLE;
      end
    endcase
  end

  always @* begin
    next_readdata = 32'h0;
    case (avs_address)
      `HMB_OFF_CTRL:      next_readdata = {24'h0, ctrl};
      `HMB_OFF_SRC1_REG0: next_readdata = {24'h0, reg0[0]};
      `HMB_OFF_SRC2_REG0: next_readdata = {24'h0, reg0[1]};
      `HMB_OFF_SRC1_REG1: next_readdata = {24'h0, reg1[0]};
      `HMB_OFF_SRC2_REG1: next_readdata = {24'h0, reg1[1]};
      `HMB_OFF_BUCK_CFG:  next_readdata = {24'h0, buck_config_register};
      `HMB_OFF_STATUS:    next_readdata = {24'h0, status_word};
      `HMB_OFF_TARGET1:   next_readdata = {20'h0, target1_mv};
      `HMB_OFF_TARGET2:   next_readdata = {20'h0, target2_mv};
      default:            next_readdata = 32'h0;
    endcase
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bus_state <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      avs_response <= 2'h0;
    end else begin
      bus_state <= next_bus_state;
      avs_waitrequest <= 1'b1;
      if (take) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= next_readdata;
        if (avs_address > `HMB_OFF_TARGET2) begin
          avs_response <= 2'h2;
        end else begin
          avs_response <= 2'h0;
        end
      end
    end
  end

  // register file; unmapped or byte-disabled writes are dropped
  wire wr_ctrl = land && (avs_address == `HMB_OFF_CTRL);
  wire wr_s1r0 = land && (avs_address == `HMB_OFF_SRC1_REG0);
  wire wr_s2r0 = land && (avs_address == `HMB_OFF_SRC2_REG0);
  wire wr_s1r1 = land && (avs_address == `HMB_OFF_SRC1_REG1);
  wire wr_s2r1 = land && (avs_address == `HMB_OFF_SRC2_REG1);
  wire wr_buck = land && (avs_address == `HMB_OFF_BUCK_CFG);
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= `HMB_CTRL_RESET;
      reg0[0] <= 8'h00;
      reg0[1] <= 8'h00;
      reg1[0] <= 8'h00;
      reg1[1] <= 8'h00;
      buck_config_register <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl <= avs_writedata[7:0];
      end
      if (wr_s1r0) begin
        reg0[0] <= avs_writedata[7:0];
      end
      if (wr_s2r0) begin
        reg0[1] <= avs_writedata[7:0];
      end
      if (wr_s1r1) begin
        reg1[0] <= avs_writedata[7:0];
      end
      if (wr_s2r1) begin
        reg1[1] <= avs_writedata[7:0];
      end
      if (wr_buck) begin
        buck_config_register <= avs_writedata[7:0];
      end
    end
  end
endmodule

// ### pkg/hmb_regs.vh
// Purpose: constants for the harvest tracking and buck control block
// Assumes: 40 MHz clock; register offsets are word addresses on a 32-bit Avalon-MM bus
// Notes: sampling and thermal times are defaults, shortened by module parameters
// How it works
// - tracking mode when mode pin high or mode bit set
// - tracking runs only in start, overdischarge and supply states
// - ratio from low three strap bits or ratio field, eight values
// - sampling period and duration from strap bits four, three or timing register
// - each period stop drawing, wait duration, then measure open-circuit voltage
// - resistance tracking on input 1 when ratio code is seven
// - resistance mode: disconnect input 1, ground reference pin, adopt loaded voltage
// - resistance tracking exists only on input 1
// - constant voltage mode regulates to configured level in active states
// - constant voltage draws nothing if open-circuit below level
// - level below low-source threshold requests sleep
// - automatic high power enabled after reset, off while enable bit zero
// - load voltage or buck off from strap bits or buck config register
// - buck starts above charge-ready, runs until below overdischarge
// - buck timing from buck config bits five to three
// - load strap code zero disables the buck
// - headroom under 0.25V uses direct connect hysteretic control
// - thermal evaluated once per period, divider biased during evaluation and one tick before it
`ifndef HMB_REGS_VH
`define HMB_REGS_VH
`define HMB_OFF_CTRL      4'h0
`define HMB_OFF_SRC1_REG0 4'h1
`define HMB_OFF_SRC2_REG0 4'h2
`define HMB_OFF_SRC1_REG1 4'h3
`define HMB_OFF_SRC2_REG1 4'h4
`define HMB_OFF_BUCK_CFG  4'h5
`define HMB_OFF_STATUS    4'h6
`define HMB_OFF_TARGET1   4'h7
`define HMB_OFF_TARGET2   4'h8
`define HMB_CTRL_USE_REGS 0
`define HMB_CTRL_HP1      1
`define HMB_CTRL_HP2      2
`define HMB_CTRL_RESET    8'h06
`define HMB_REG0_MODE     7
`define HMB_REG0_LVL_LSB  3
`define HMB_RESISTANCE_TRACKING_MODE_CODE     3'h7
`define HMB_BUCK_OFF      3'h0
`define HMB_HEADROOM_MV   250
`define HMB_ST_RESET      3'h0
`define HMB_ST_SENSE      3'h1
`define HMB_ST_START      3'h2
`define HMB_ST_OVDIS      3'h3
`define HMB_ST_SUPPLY     3'h4
`define HMB_ST_SLEEP      3'h5
`define HMB_TICK_US       1
`define HMB_CLK_MHZ       40
`define HMB_TICK_CYC      (`HMB_TICK_US * `HMB_CLK_MHZ)
`endif

// ### testbench/hmb_checker.sv
// Purpose: temporal checks on the tracking, buck and thermal ports
// Assumes: one clock, asynchronous active-low reset
// Notes: waits allow for one register stage on every output
`timescale 1ns/1ps
module hmb_checker #(
  parameter THERM_EVAL_US = 32'd100
) (
  input wire        clock,
  input wire        rst_b,
  input wire        avs_read,
  input wire        avs_write,
  input wire        avs_waitrequest,
  input wire [2:0]  device_state,
  input wire [11:0] sto_mv,
  input wire [11:0] load_mv,
  input wire [11:0] charge_ready_threshold,
  input wire [11:0] overdischarge_threshold,
  input wire [1:0]  source_energy_high,
  input wire [1:0]  source_connect,
  input wire [1:0]  tracking_active,
  input wire        resistance_ref_ground,
  input wire [1:0]  high_power_mode,
  input wire        buck_enable,
  input wire [2:0]  buck_voltage_code,
  input wire        direct_connect,
  input wire        thermal_divider_bias_pin,
  input wire        thermal_sample_strobe
);
  localparam int BIAS_MAX = THERM_EVAL_US * 40 + 2;
  logic [31:0] bias_cycles;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) bias_cycles <= 32'h0;
    else bias_cycles <= thermal_divider_bias_pin ? bias_cycles + 32'h1 : 32'h0;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  track_idle_a: assert property ((device_state < 3'h2 || device_state > 3'h4) [*2] |-> tracking_active == 2'h0)
    else $error("tracking outside active states");
  hp_gate_a: assert property (!source_energy_high[0] [*3] |-> !high_power_mode[0])
    else $error("high power without source energy");
  ref_ground_a: assert property (resistance_ref_ground && $past(resistance_ref_ground) |-> !source_connect[0])
    else $error("reference grounded while input connected");
  buck_start_a: assert property ($rose(buck_enable) |-> $past(sto_mv) > $past(charge_ready_threshold))
    else $error("buck started below charge ready");
  buck_stop_a: assert property ($fell(buck_enable) |-> buck_voltage_code == 3'h0
    || $past(sto_mv) < $past(overdischarge_threshold)) else $error("buck stopped above overdischarge");
  direct_gate_a: assert property (({1'b0, sto_mv} >= {1'b0, load_mv} + 13'h0FA) [*2] |-> !direct_connect)
    else $error("direct connect with ample headroom");
  bias_len_a: assert property (bias_cycles <= BIAS_MAX)
    else $error("divider biased past evaluation");
  strobe_bias_a: assert property (thermal_sample_strobe |-> thermal_divider_bias_pin || $past(thermal_divider_bias_pin))
    else $error("thermal sample without bias");
endmodule
bind hmb_top hmb_checker #(.THERM_EVAL_US(THERM_EVAL_US)) chk_u (.clock, .rst_b, .avs_read, .avs_write,
  .avs_waitrequest, .device_state, .sto_mv, .load_mv, .charge_ready_threshold, .overdischarge_threshold,
  .source_energy_high, .source_connect, .tracking_active, .resistance_ref_ground, .high_power_mode,
  .buck_enable, .buck_voltage_code, .direct_connect, .thermal_divider_bias_pin, .thermal_sample_strobe);

// ### testbench/hmb_far_model.sv
// Purpose: harvesters, battery and load seen by the control block
// Assumes: sources settle within one cycle
// Notes: a loaded reference halves the open-circuit level
`timescale 1ns/1ps
module hmb_far_model (
  input  wire [1:0]  source_connect,
  input  wire        resistance_ref_ground,
  input  wire        direct_connect,
  input  wire [11:0] target1_mv,
  input  wire [11:0] target2_mv,
  input  wire [11:0] voc1,
  input  wire [11:0] voc2,
  input  wire [11:0] sto_set,
  input  wire [11:0] load_set,
  output wire [11:0] src1_mv,
  output wire [11:0] src2_mv,
  output wire [11:0] sto_mv,
  output wire [11:0] load_mv
);
  // drawn sources sag to target, released ones rise to open circuit (half of it on input 1 with grounded reference)
  assign src1_mv = !source_connect[0] ? (resistance_ref_ground ? voc1 >> 1 : voc1) :
    (target1_mv != 12'h000 && target1_mv < voc1) ? target1_mv : voc1;
  assign src2_mv = (source_connect[1] && target2_mv != 12'h000 && target2_mv < voc2) ? target2_mv : voc2;
  assign sto_mv = sto_set;
  assign load_mv = direct_connect ? sto_set : load_set;
endmodule

// ### testbench/tb.sv
// Purpose: directed test of the tracking and buck control block
// Assumes: shortened sampling and thermal times
// Notes: open-circuit levels of 2000 mV keep ratio results exact
`timescale 1ns/1ps
module tb;
  logic        clock, rst_b, avs_read, avs_write;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, rd;
  logic [2:0]  device_state, load_cfg_pins;
  logic [1:0]  source_regulation_select_pin, source_energy_high, rsp;
  logic [4:0]  src1_cfg_pins, src2_cfg_pins;
  logic [11:0] load_target_mv, charge_ready_threshold, overdischarge_threshold, low_source_threshold;
  logic [11:0] voc1, voc2, sto_set, load_set;
  wire  [31:0] avs_readdata;
  wire  [11:0] src1_mv, src2_mv, sto_mv, load_mv, target1_mv, target2_mv;
  wire  [2:0]  buck_voltage_code, buck_timing_code;
  wire  [1:0]  avs_response, source_connect, tracking_active, high_power_mode;
  wire         avs_waitrequest, resistance_ref_ground, sleep_request, buck_enable, direct_connect;
  wire         thermal_divider_bias_pin, thermal_sample_strobe;
  int          bad_count, checks_done, i, c;
  hmb_top #(.PERIOD_BASE_US(20), .SAMPLE_BASE_US(5), .THERM_US(30), .THERM_EVAL_US(4)) dut_u (.*);
  hmb_far_model far_u (.*);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    for (k = 0; k < 50 && avs_waitrequest !== 1'b0; k++) @(posedge clock);
    if (k == 50) bad_count++;
    if (k == 50) report_and_stop();
    rd = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    repeat (100000) @(posedge clock);
    bad_count++;
    report_and_stop();
  end
  initial begin
    {rst_b, avs_read, avs_write, avs_address, avs_writedata, load_cfg_pins} = '0;
    {source_regulation_select_pin, source_energy_high, src1_cfg_pins, src2_cfg_pins} = '0;
    {device_state, avs_byteenable} = {3'h4, 4'hF};
    {voc1, voc2, sto_set, load_set} = {12'h7D0, 12'h7D0, 12'h960, 12'h3E8};
    {load_target_mv, charge_ready_threshold} = {12'hB22, 12'hAF0};
    {overdischarge_threshold, low_source_threshold} = {12'h9C4, 12'h12C};
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    bus(1'b0, 4'h0, 32'h0);
    chk("ctrl", 32'h06, rd);
    bus(1'b0, 4'h9, 32'h0);
    chk("response", 32'h2, {30'h0, rsp});
    $display("test bus done");
    source_regulation_select_pin <= 2'h3;
    src1_cfg_pins <= 5'h03;
    src2_cfg_pins <= 5'h03;
    for (i = 0; i < 3000 && target1_mv !== 12'h5DC; i++) @(posedge clock);
    chk("target1", 32'h5DC, {20'h0, target1_mv});
    src1_cfg_pins <= 5'h07;
    src2_cfg_pins <= 5'h07;
    for (i = 0; i < 3000 && target2_mv !== 12'h7D0; i++) @(posedge clock);
    chk("target2", 32'h7D0, {20'h0, target2_mv});
    for (i = 0; i < 3000 && target1_mv !== 12'h3E8; i++) @(posedge clock);
    chk("target1", 32'h3E8, {20'h0, target1_mv});
    device_state <= 3'h5;
    for (i = 0; i < 20 && tracking_active !== 2'h0; i++) @(posedge clock);
    chk("tracking", 32'h0, {30'h0, tracking_active});
    device_state <= 3'h4;
    $display("test pins done");
    bus(1'b1, 4'h0, 32'h07);
    for (c = 0; c < 8; c++) begin
      bus(1'b1, 4'h1, 32'h80 | c);
      for (i = 0; i < 3000 && target1_mv !== (c == 7 ? 12'h3E8 : 12'(125 * (9 + c))); i++) @(posedge clock);
      chk("target1", (c == 7 ? 12'h3E8 : 12'(125 * (9 + c))), {20'h0, target1_mv});
    end
    bus(1'b1, 4'h2, 32'h20);
    for (i = 0; i < 20 && target2_mv !== 12'h400; i++) @(posedge clock);
    chk("target2", 32'h400, {20'h0, target2_mv});
    bus(1'b1, 4'h2, 32'h78);
    for (i = 0; i < 3000 && source_connect[1] !== 1'b0; i++) @(posedge clock);
    chk("connect2", 32'h0, {31'h0, source_connect[1]});
    bus(1'b1, 4'h2, 32'h08);
    for (i = 0; i < 20 && sleep_request !== 1'b1; i++) @(posedge clock);
    chk("sleep", 32'h1, {31'h0, sleep_request});
    source_energy_high <= 2'h3;
    for (i = 0; i < 3000 && high_power_mode !== 2'h3; i++) @(posedge clock);
    chk("high power", 32'h3, {30'h0, high_power_mode});
    bus(1'b1, 4'h0, 32'h01);
    for (i = 0; i < 20 && high_power_mode !== 2'h0; i++) @(posedge clock);
    chk("high power", 32'h0, {30'h0, high_power_mode});
    $display("test registers done");
    bus(1'b1, 4'h5, 32'h2B);
    sto_set <= 12'hBB8;
    for (i = 0; i < 20 && buck_enable !== 1'b1; i++) @(posedge clock);
    chk("buck codes", 32'h2B, {26'h0, buck_timing_code, buck_voltage_code});
    sto_set <= 12'hA8C;
    repeat (20) @(posedge clock);
    chk("buck on", 32'h1, {31'h0, buck_enable});
    sto_set <= 12'h960;
    for (i = 0; i < 20 && buck_enable !== 1'b0; i++) @(posedge clock);
    sto_set <= 12'hA8C;
    repeat (20) @(posedge clock);
    chk("buck off", 32'h0, {31'h0, buck_enable});
    sto_set <= 12'hBB8;
    load_set <= 12'hAF0;
    for (i = 0; i < 50 && direct_connect !== 1'b1; i++) @(posedge clock);
    chk("direct", 32'h1, {31'h0, direct_connect});
    bus(1'b1, 4'h0, 32'h06);
    repeat (20) @(posedge clock);
    chk("buck strap off", 32'h0, {31'h0, buck_enable});
    load_cfg_pins <= 3'h2;
    for (i = 0; i < 20 && buck_enable !== 1'b1; i++) @(posedge clock);
    chk("buck strap", 32'h2, {29'h0, buck_voltage_code});
    $display("test buck done");
    for (i = 0; i < 3000 && thermal_sample_strobe !== 1'b1; i++) @(posedge clock);
    chk("thermal bias", 32'h1, {31'h0, thermal_divider_bias_pin});
    $display("test thermal done");
    report_and_stop();
  end
endmodule
